//--- rtl/csd_pkg.sv
package csd_pkg;

  // APB register byte offsets.
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_OPCODE = 8'h04;
  localparam logic [7:0] OFF_FLAG   = 8'h08;
  localparam logic [7:0] OFF_HLO    = 8'h0C;
  localparam logic [7:0] OFF_HHI    = 8'h10;
  localparam logic [7:0] OFF_FLEN   = 8'h14;
  localparam logic [7:0] OFF_VLEN   = 8'h18;
  localparam logic [7:0] OFF_GO     = 8'h1C;
  localparam logic [7:0] OFF_STAT   = 8'h20;
  localparam logic [7:0] OFF_RSTAT  = 8'h24;
  localparam logic [7:0] OFF_RHLO   = 8'h28;
  localparam logic [7:0] OFF_RHHI   = 8'h2C;
  localparam logic [5:0] FIX_WBASE  = 6'h10;
  localparam int         FIX_WORDS  = 14;

  // Field positions and reset values.
  localparam int          CTRL_REV1_BIT = 0;
  localparam int          CTRL_SL_LSB   = 1;
  localparam int          SL_BITS       = 5;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_DONE_BIT = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] SESSION_FLAG  = 32'h0000_0001;

  // Operation status codes.
  localparam logic [7:0] STATUS_OK           = 8'h00;
  localparam logic [7:0] STATUS_ERR          = 8'h01;
  localparam logic [7:0] STATUS_AUTH_FAILURE = 8'h02;
  localparam logic [7:0] STATUS_UNSUPPORTED  = 8'h03;
  localparam logic [7:0] STATUS_BAD_SESSION  = 8'h04;
  localparam logic [7:0] STATUS_NO_FREE_SLOT = 8'h05;

  // Services and sub-operations, opcode = service * 256 + sub-operation.
  localparam logic [7:0] SVC_CIPHER = 8'h00;
  localparam logic [7:0] SVC_HASH   = 8'h01;
  localparam logic [7:0] SVC_MAC    = 8'h02;
  localparam logic [7:0] SVC_AEAD   = 8'h03;
  localparam logic [7:0] SUB_DATA0  = 8'h00;
  localparam logic [7:0] SUB_DATA1  = 8'h01;
  localparam logic [7:0] SUB_CREATE = 8'h02;
  localparam logic [7:0] SUB_DESTROY = 8'h03;

  // Parameter-area encodings.
  localparam logic [31:0] DIRECTION_ENCRYPT = 32'h0000_0001;
  localparam logic [31:0] DIRECTION_DECRYPT = 32'h0000_0002;
  localparam logic [31:0] SEL_CIPHER        = 32'h0000_0001;
  localparam logic [31:0] SEL_CHAIN         = 32'h0000_0002;
  localparam logic [31:0] ORDER_HASH_FIRST  = 32'h0000_0001;
  localparam logic [31:0] ORDER_CIPHER_FIRST = 32'h0000_0002;
  localparam logic [31:0] HMODE_PLAIN       = 32'h0000_0001;
  localparam logic [31:0] HMODE_AUTH        = 32'h0000_0002;
  localparam logic [31:0] HMODE_NESTED      = 32'h0000_0003;
  localparam logic [31:0] ALGO_NONE         = 32'h0000_0000;

  // Fixed-area lengths in bytes.
  localparam logic [31:0] FLF_LEGACY  = 32'h0000_0038;
  localparam logic [31:0] FLF_HASH    = 32'h0000_0008;
  localparam logic [31:0] FLF_MAC     = 32'h0000_0010;
  localparam logic [31:0] FLF_SYM     = 32'h0000_0038;
  localparam logic [31:0] FLF_AEAD    = 32'h0000_0018;
  localparam logic [31:0] FLF_DESTROY = 32'h0000_0008;

  // Session table.
  localparam int NSLOT  = 16;
  localparam int SLOT_W = 4;

  typedef enum logic [1:0] {OPK_CREATE, OPK_DESTROY, OPK_DATA, OPK_BAD} csd_kind_t;

  typedef struct packed {
    logic [31:0] opcode;
    logic [31:0] flag;
    logic [63:0] handle;
    logic [31:0] flf_len;
    logic [31:0] vlf_len;
  } csd_req_t;

  typedef struct packed {
    logic [7:0]  status;
    logic [63:0] handle;
  } csd_res_t;

endpackage

//--- rtl/csd_decoder.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module csd_decoder (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Verdict of the external tag check.
  input  wire logic        engine_auth_fail
);
  import csd_pkg::*;

  typedef enum logic {ST_IDLE, ST_EXEC} csd_state_t;

  logic [31:0]      ctrl_q, ctrl_d;
  csd_req_t         req_q, req_d;
  logic [31:0]      fix_q [FIX_WORDS];
  logic [31:0]      fix_d [FIX_WORDS];
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;
  csd_state_t       state_q, state_d;
  csd_res_t         res_q, res_d;
  logic             done_q, done_d;
  logic [NSLOT-1:0] live_q, live_d;
  logic [7:0]       svc_q [NSLOT];
  logic [7:0]       svc_d [NSLOT];

  logic             acc;
  logic             wr;
  logic             go;
  logic             done_clr;
  logic             mapped;
  logic [5:0]       widx;
  logic [5:0]       fidx;
  logic             rev1;
  logic [SL_BITS-1:0] stateless;

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign acc       = psel && penable && pready_q;
  assign wr        = acc && pwrite && !pslverr_q;
  assign widx      = paddr[7:2];
  assign fidx      = widx - FIX_WBASE;
  assign rev1      = ctrl_q[CTRL_REV1_BIT];
  assign stateless = ctrl_q[CTRL_SL_LSB +: SL_BITS];
  assign go        = wr && (paddr == OFF_GO) && (state_q == ST_IDLE);
  assign done_clr  = wr && (paddr == OFF_STAT) && pwdata[STAT_DONE_BIT];

  function automatic csd_kind_t kind_of(input logic [31:0] op);
    csd_kind_t k;
    k = OPK_BAD;
    if (op[31:16] == 16'h0000 && op[15:8] <= SVC_AEAD) begin
      case (op[7:0])
        SUB_CREATE:  k = OPK_CREATE;
        SUB_DESTROY: k = OPK_DESTROY;
        SUB_DATA0:   k = OPK_DATA;
        SUB_DATA1:   k = (op[15:8] == SVC_CIPHER || op[15:8] == SVC_AEAD) ? OPK_DATA
                                                                          : OPK_BAD;
        default:     k = OPK_BAD;
      endcase
    end
    return k;
  endfunction

  function automatic logic dir_ok(input logic [31:0] d);
    return (d == DIRECTION_ENCRYPT) || (d == DIRECTION_DECRYPT);
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    logic [5:0] w;
    w = a[7:2];
    return (a[1:0] == 2'b00) && ((a <= OFF_RHHI) ||
           ((w >= FIX_WBASE) && (w < FIX_WBASE + 6'(FIX_WORDS))));
  endfunction

  // APB slave: one wait state, then the answer.
  always_comb begin
    ctrl_d    = ctrl_q;
    req_d     = req_q;
    fix_d     = fix_q;
    mapped    = is_mapped(paddr);
    pready_d  = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !mapped;
    prdata_d  = prdata_q;
    if (psel && penable && !pready_q) begin
      prdata_d = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          OFF_CTRL:   prdata_d = ctrl_q;
          OFF_OPCODE: prdata_d = req_q.opcode;
          OFF_FLAG:   prdata_d = req_q.flag;
          OFF_HLO:    prdata_d = req_q.handle[31:0];
          OFF_HHI:    prdata_d = req_q.handle[63:32];
          OFF_FLEN:   prdata_d = req_q.flf_len;
          OFF_VLEN:   prdata_d = req_q.vlf_len;
          OFF_STAT:   prdata_d = {30'h0000_0000, done_q, state_q == ST_EXEC};
          OFF_RSTAT:  prdata_d = {24'h00_0000, res_q.status};
          OFF_RHLO:   prdata_d = res_q.handle[31:0];
          OFF_RHHI:   prdata_d = res_q.handle[63:32];
          default: begin
            if (mapped && paddr > OFF_RHHI) begin
              prdata_d = fix_q[fidx[3:0]];
            end
          end
        endcase
      end
    end
    if (wr && state_q == ST_IDLE) begin
      case (paddr)
        OFF_CTRL:   ctrl_d = {26'h000_0000, pwdata[5:0]};
        OFF_OPCODE: req_d.opcode = pwdata;
        OFF_FLAG:   req_d.flag = pwdata;
        OFF_HLO:    req_d.handle[31:0] = pwdata;
        OFF_HHI:    req_d.handle[63:32] = pwdata;
        OFF_FLEN:   req_d.flf_len = pwdata;
        OFF_VLEN:   req_d.vlf_len = pwdata;
        default: begin
          if (paddr > OFF_RHHI) begin
            fix_d[fidx[3:0]] = pwdata;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_q    <= CTRL_RESET;
      req_q     <= '0;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      req_q     <= req_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < FIX_WORDS; gi++) begin : g_fix
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          fix_q[gi] <= 32'h0000_0000;
        end else begin
          fix_q[gi] <= fix_d[gi];
        end
      end
    end
  endgenerate

  // Command execution.
  csd_kind_t        kind;
  logic [7:0]       svc;
  logic [31:0]      flf_need;
  logic [31:0]      auth_len;
  logic             bad;
  logic             unsup;
  logic             found;
  logic [SLOT_W-1:0] free_idx;
  logic             h_ok;
  logic [SLOT_W:0]  hm1;
  logic [SLOT_W-1:0] hidx;
  logic [7:0]       st;

  always_comb begin
    kind     = kind_of(req_q.opcode);
    svc      = req_q.opcode[15:8];
    found    = 1'b0;
    free_idx = '0;
    for (int i = NSLOT - 1; i >= 0; i--) begin
      if (!live_q[i]) begin
        found    = 1'b1;
        free_idx = SLOT_W'(i);
      end
    end
    hm1  = req_q.handle[SLOT_W:0] - (SLOT_W + 1)'(1);
    hidx = hm1[SLOT_W-1:0];
    h_ok = (req_q.handle[63:SLOT_W+1] == '0) && (req_q.handle[SLOT_W:0] != '0) &&
           (req_q.handle[SLOT_W:0] <= (SLOT_W + 1)'(NSLOT)) && live_q[hidx] &&
           (svc_q[hidx] == svc);
    bad      = 1'b0;
    unsup    = 1'b0;
    auth_len = 32'h0000_0000;
    flf_need = FLF_LEGACY;
    case (svc)
      SVC_HASH: begin
        if (rev1) flf_need = FLF_HASH;
        bad   = req_q.vlf_len != 32'h0000_0000;
        unsup = fix_q[0] == ALGO_NONE;
      end
      SVC_MAC: begin
        if (rev1) flf_need = FLF_MAC;
        bad   = req_q.vlf_len != fix_q[2];
        unsup = fix_q[0] == ALGO_NONE;
      end
      SVC_AEAD: begin
        if (rev1) flf_need = FLF_AEAD;
        bad   = (req_q.vlf_len != fix_q[1]) || !dir_ok(fix_q[4]);
        unsup = fix_q[0] == ALGO_NONE;
      end
      default: begin
        if (rev1) flf_need = FLF_SYM;
        if (fix_q[12] == SEL_CIPHER) begin
          bad   = (req_q.vlf_len != fix_q[1]) || !dir_ok(fix_q[2]);
          unsup = fix_q[0] == ALGO_NONE;
        end else if (fix_q[12] == SEL_CHAIN) begin
          if (fix_q[1] == HMODE_AUTH) auth_len = fix_q[8];
          bad = (fix_q[0] != ORDER_HASH_FIRST && fix_q[0] != ORDER_CIPHER_FIRST) ||
                !dir_ok(fix_q[4]) ||
                (req_q.vlf_len != fix_q[3] + auth_len);
          unsup = (fix_q[1] != HMODE_PLAIN && fix_q[1] != HMODE_AUTH &&
                   fix_q[1] != HMODE_NESTED) || fix_q[2] == ALGO_NONE ||
                  fix_q[6] == ALGO_NONE;
        end else begin
          unsup = 1'b1;
        end
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    res_d   = res_q;
    live_d  = live_q;
    svc_d   = svc_q;
    done_d  = done_q && !done_clr;
    st      = STATUS_ERR;
    case (state_q)
      ST_IDLE: begin
        if (go) state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = ST_IDLE;
        case (kind)
          OPK_CREATE: begin
            if (req_q.flf_len != flf_need) st = STATUS_ERR;
            else if (unsup) st = STATUS_UNSUPPORTED;
            else if (bad) st = STATUS_ERR;
            else if (!found) st = rev1 ? STATUS_NO_FREE_SLOT : STATUS_ERR;
            else st = STATUS_OK;
            res_d.handle = 64'h0000_0000_0000_0000;
            if (st == STATUS_OK) begin
              live_d[free_idx] = 1'b1;
              svc_d[free_idx]  = svc;
              res_d.handle     = 64'(free_idx) + 64'h0000_0000_0000_0001;
            end
          end
          OPK_DESTROY: begin
            res_d.handle = 64'h0000_0000_0000_0000;
            if (req_q.flf_len == (rev1 ? FLF_DESTROY : FLF_LEGACY) && h_ok &&
                req_q.vlf_len == 32'h0000_0000) begin
              st           = STATUS_OK;
              live_d[hidx] = 1'b0;
            end else begin
              st = STATUS_ERR;
            end
          end
          OPK_DATA: begin
            res_d.handle = 64'h0000_0000_0000_0000;
            if (rev1 && req_q.flag != SESSION_FLAG) begin
              if (!stateless[svc[2:0]]) st = STATUS_ERR;
              else st = STATUS_OK;
            end else if (!h_ok) begin
              st = STATUS_BAD_SESSION;
            end else begin
              st = STATUS_OK;
            end
            if (st == STATUS_OK && svc == SVC_AEAD && req_q.opcode[7:0] == SUB_DATA1 &&
                engine_auth_fail) begin
              st = STATUS_AUTH_FAILURE;
            end
          end
          default: begin
            st           = STATUS_UNSUPPORTED;
            res_d.handle = 64'h0000_0000_0000_0000;
          end
        endcase
        res_d.status = st;
        done_d       = 1'b1;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      res_q   <= '0;
      done_q  <= 1'b0;
      live_q  <= '0;
    end else begin
      state_q <= state_d;
      res_q   <= res_d;
      done_q  <= done_d;
      live_q  <= live_d;
    end
  end

  generate
    for (gi = 0; gi < NSLOT; gi++) begin : g_svc
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          svc_q[gi] <= 8'h00;
        end else begin
          svc_q[gi] <= svc_d[gi];
        end
      end
    end
  endgenerate

endmodule

//--- tb/csd_chk.sv
`timescale 1ns/1ps
module csd_chk
  import csd_pkg::*;
(
  // Clock and reset.
  input wire logic        clock,
  input wire logic        sys_rst,
  // APB.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Tag check verdict.
  input wire logic        engine_auth_fail
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [31:0] opc_q;
  logic [31:0] gop_q;
  logic        rv_q;
  logic        grv_q;
  logic        sv_q;
  logic [7:0]  st_q;
  wire logic   done = psel & penable & pready;
  wire logic   st_rd = done & ~pwrite & (paddr == OFF_RSTAT);
  // Keeps the opcode and revision of the last command and the last status read.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      opc_q <= 32'h0;
      gop_q <= 32'h0;
      rv_q  <= 1'b0;
      grv_q <= 1'b0;
      sv_q  <= 1'b0;
      st_q  <= 8'h0;
    end else if (done && pwrite) begin
      if (paddr == OFF_OPCODE) opc_q <= pwdata;
      if (paddr == OFF_CTRL) rv_q <= pwdata[CTRL_REV1_BIT];
      if (paddr == OFF_GO) begin
        gop_q <= opc_q;
        grv_q <= rv_q;
        sv_q  <= 1'b0;
      end
    end else if (st_rd) begin
      sv_q <= 1'b1;
      st_q <= prdata[7:0];
    end
  end
  property p_wait; psel && penable && !pready |=> pready; endproperty
  property p_rise; $rose(pready) |-> $past(penable); endproperty
  property p_range; st_rd |-> prdata < 32'h6; endproperty
  property p_auth; st_rd && prdata == 32'h2 |-> gop_q == 32'h301; endproperty
  property p_slot; st_rd && prdata == 32'h5 |-> grv_q && gop_q[7:0] == SUB_CREATE; endproperty
  property p_sess; st_rd && prdata == 32'h4 |-> gop_q[7:1] == 7'h0; endproperty
  property p_unk; st_rd && gop_q[31:10] != 22'h0 |-> prdata == 32'h3; endproperty
  property p_dest; st_rd && gop_q[31:10] == 22'h0 && gop_q[7:0] == SUB_DESTROY |-> prdata < 32'h2;
  endproperty
  property p_hzero; done && !pwrite && paddr == OFF_RHLO && sv_q && st_q != 8'h0 |-> prdata == 32'h0;
  endproperty
  property p_err; pready && (paddr[1:0] != 2'h0 || paddr > 8'h74 || (paddr > 8'h2C && paddr < 8'h40))
    |-> pslverr; endproperty
  a_wait: assert property (p_wait) else $error("no ready after wait");
  a_rise: assert property (p_rise) else $error("ready outside access");
  a_range: assert property (p_range) else $error("status out of range");
  a_auth: assert property (p_auth) else $error("auth failure on wrong op");
  a_slot: assert property (p_slot) else $error("no slot without revision one");
  a_sess: assert property (p_sess) else $error("bad session on non data op");
  a_unk: assert property (p_unk) else $error("unknown opcode not unsupported");
  a_dest: assert property (p_dest) else $error("destroy status not ok or error");
  a_hzero: assert property (p_hzero) else $error("handle on failure");
  a_err: assert property (p_err) else $error("unmapped access accepted");
  c_slot: cover property (st_rd && prdata == 32'h5);
  c_auth: cover property (st_rd && prdata == 32'h2);
  c_sess: cover property (st_rd && prdata == 32'h4);
endmodule

//--- tb/csd_host.sv
`timescale 1ns/1ps
module csd_host (
  // Clock.
  input wire logic         clock,
  // APB master.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input wire logic         pready,
  // Stuck transfer.
  output logic             hung
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hung = 1'b0;
  end
  // One transfer; a released bus shows inverted address and data.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hung <= 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule

//--- tb/test_csd_decoder.sv
`timescale 1ns/1ps
module test_csd_decoder;
  import csd_pkg::*;
  logic clock, sys_rst, engine_auth_fail, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lh;
  logic [31:0] seed = 32'h38;
  logic [31:0] fw [FIX_WORDS];
  logic [NSLOT-1:0] live;
  logic [32:0] expq [$];
  int n_errors, total_checks;
  csd_decoder DUT (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .engine_auth_fail(engine_auth_fail));
  csd_host h (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .hung(hung));
  always #12.5 clock = ~clock;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compares each read with the oldest expectation.
  always @(posedge clock) begin
    if (psel && penable && pready && !pwrite) begin
      total_checks++;
      if (expq.size() == 0 || {pslverr, prdata} !== expq[0]) begin
        n_errors++;
        $display("wrong value at %0t: addr %h read %h", $time, paddr, prdata);
      end
      if (expq.size() != 0) void'(expq.pop_front());
    end
    if (hung) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    h.xfer(1'b1, a, d);
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    expq.push_back({er, e});
    h.xfer(1'b0, a, 32'h0);
  endtask
  // Header, lengths, fixed words, go, then the result area.
  task automatic run(input logic [31:0] ct, op, fg, hl, fl, vl, input logic [7:0] st,
                     input logic [1:0] kd);
    int k;
    logic [31:0] eh;
    eh = 32'h0;
    wr(OFF_CTRL, ct);
    wr(OFF_OPCODE, op);
    wr(OFF_FLAG, fg);
    wr(OFF_HLO, hl);
    wr(OFF_HHI, 32'h0);
    wr(OFF_FLEN, fl);
    wr(OFF_VLEN, vl);
    for (k = 0; k < FIX_WORDS; k++) wr(8'({FIX_WBASE, 2'h0}) + 8'(4 * k), fw[k]);
    wr(OFF_GO, xs());
    chk(OFF_RSTAT, {24'h0, st});
    if (kd == 2'h1) begin
      if (st == STATUS_OK) begin
        for (k = NSLOT - 1; k >= 0; k--) if (!live[k]) eh = 32'(k + 1);
        live[int'(eh) - 1] = 1'b1;
        lh = eh;
      end
      chk(OFF_RHLO, eh);
      chk(OFF_RHHI, 32'h0);
    end
    if (kd == 2'h2 && st == STATUS_OK) live[int'(hl) - 1] = 1'b0;
  endtask
  initial begin
    int k, s, b;
    logic [31:0] ah;
    logic [31:0] ops [3];
    ops = '{32'h402, 32'h104, 32'h201};
    clock = 1'b0;
    sys_rst = 1'b1;
    engine_auth_fail = 1'b0;
    live = '0;
    fw = '{default: 32'h0};
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    chk(OFF_CTRL, CTRL_RESET);
    chk(8'h78, 32'h0, 1'b1);
    chk(8'h06, 32'h0, 1'b1);
    fw[0] = 32'h1;
    fw[1] = 32'h20;
    run(0, 32'h102, SESSION_FLAG, 0, FLF_LEGACY, 0, STATUS_OK, 1);
    chk(OFF_STAT, 32'h2);
    wr(OFF_STAT, 32'h2);
    chk(OFF_STAT, 32'h0);
    run(0, 32'h102, SESSION_FLAG, 0, FLF_HASH, 0, STATUS_ERR, 1);
    run(0, 32'h102, SESSION_FLAG, 0, FLF_LEGACY, 4, STATUS_ERR, 1);
    for (k = 0; k < 3; k++) run(0, ops[k], SESSION_FLAG, 0, 0, 0, STATUS_UNSUPPORTED, 1);
    fw[1] = 32'h10;
    fw[12] = SEL_CIPHER;
    for (k = 1; k < 4; k++) begin
      fw[2] = 32'(k);
      run(0, 32'h2, SESSION_FLAG, 0, FLF_SYM, 16, k < 3 ? STATUS_OK : STATUS_ERR, 1);
    end
    fw[1] = 32'h1 + (xs() & 32'h1F);
    fw[2] = DIRECTION_ENCRYPT;
    run(0, 32'h2, SESSION_FLAG, 0, FLF_SYM, fw[1] + 1, STATUS_ERR, 1);
    fw[0] = ALGO_NONE;
    run(0, 32'h2, SESSION_FLAG, 0, FLF_SYM, fw[1], STATUS_UNSUPPORTED, 1);
    fw = '{0: ORDER_CIPHER_FIRST, 1: HMODE_AUTH, 2: 1, 3: 16, 4: DIRECTION_ENCRYPT, 6: 1, 7: 32,
           8: 8, 12: SEL_CHAIN, default: 0};
    run(0, 32'h2, SESSION_FLAG, 0, FLF_SYM, 24, STATUS_OK, 1);
    fw[1] = HMODE_PLAIN;
    fw[9] = xs();
    run(0, 32'h2, SESSION_FLAG, 0, FLF_SYM, 16, STATUS_OK, 1);
    fw = '{0: 1, 1: 32, 2: 8, default: 0};
    run(0, 32'h202, SESSION_FLAG, 0, FLF_LEGACY, 8, STATUS_OK, 1);
    run(0, 32'h202, SESSION_FLAG, 0, FLF_LEGACY, 7, STATUS_ERR, 1);
    fw = '{0: 1, 1: 16, 2: 16, 4: DIRECTION_DECRYPT, default: 0};
    run(0, 32'h302, SESSION_FLAG, 0, FLF_LEGACY, 16, STATUS_OK, 1);
    ah = lh;
    engine_auth_fail <= 1'b1;
    run(0, 32'h301, SESSION_FLAG, ah, 0, 0, STATUS_AUTH_FAILURE, 0);
    run(0, 32'h0, SESSION_FLAG, 2, 0, 0, STATUS_OK, 0);
    engine_auth_fail <= 1'b0;
    run(0, 32'h301, SESSION_FLAG, ah, 0, 0, STATUS_OK, 0);
    run(0, 32'h0, SESSION_FLAG, 32'h20 | xs(), 0, 0, STATUS_BAD_SESSION, 0);
    run(0, 32'h103, SESSION_FLAG, 1, FLF_LEGACY, 0, STATUS_OK, 2);
    run(0, 32'h103, SESSION_FLAG, 1, FLF_LEGACY, 0, STATUS_ERR, 2);
    run(0, 32'h103, SESSION_FLAG, 2, FLF_LEGACY, 0, STATUS_ERR, 2);
    for (s = 0; s < 4; s++) for (b = 0; b < 2; b++)
      run(32'h1 | (32'(b) << (CTRL_SL_LSB + s)), 32'(s) << 8, 0, 0, 0, 0,
          b ? STATUS_OK : STATUS_ERR, 0);
    run(1, 32'h0, SESSION_FLAG, 2, 0, 0, STATUS_OK, 0);
    fw = '{0: 1, 1: 32, default: 0};
    for (k = 0; k < NSLOT && live != '1; k++)
      run(1, 32'h102, SESSION_FLAG, 0, FLF_HASH, 0, STATUS_OK, 1);
    run(1, 32'h102, SESSION_FLAG, 0, FLF_HASH, 0, STATUS_NO_FREE_SLOT, 1);
    run(0, 32'h102, SESSION_FLAG, 0, FLF_LEGACY, 0, STATUS_ERR, 1);
    tally_and_finish();
  end
endmodule
bind csd_decoder csd_chk u_chk (.clock(clock), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .engine_auth_fail(engine_auth_fail));
